// file: logic/port_pins_cfg.svh
`ifndef PORT_PINS_CFG_SVH
`define PORT_PINS_CFG_SVH

// register indices; the byte address on the bus is four times the index
`define S_PULL_ON_IDX 8'h0c
`define S_PULL_POLARITY_IDX 8'h0d
`define S_OPEN_DRAIN_IDX 8'h0e
`define M_DATA_IDX 8'h10
`define M_PIN_LEVEL_IDX 8'h11
`define M_DIRECTION_IDX 8'h12
`define M_DRIVE_IDX 8'h13
`define M_PULL_ON_IDX 8'h14

// reset values
`define S_PULL_ON_RST 8'h0f
`define S_PULL_POLARITY_RST 8'h00
`define S_OPEN_DRAIN_RST 8'h00
`define M_DATA_RST 8'h00
`define M_DIRECTION_RST 8'h00
`define M_DRIVE_RST 8'h00
`define M_PULL_ON_RST 8'h3f

// field positions of the peripheral-owned port m pins
`define M_RX_PIN 0
`define M_TX_PIN 1
`define M_SPI_LSB 2

// cycles from a direction change until reads reflect it
`define DIR_SETTLE_CYCLES 2

`endif

// file: logic/port_pins_pkg.sv
package port_pins_pkg;

    typedef logic [7:0] reg_byte_t;
    typedef logic [31:0] apb_word_t;

    typedef enum logic [2:0] {
        APB_IDLE = 3'b001,
        APB_SETUP = 3'b010,
        APB_ACCESS = 3'b100
    } apb_phase_t;

endpackage

// file: logic/port_pin_control.sv
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "port_pins_cfg.svh"
// What this block does
// (R1) port s polarity 0 selects pull-up, 1 pull-down, when enabled on input or wired-or
// (R2) port s open-drain bit 1 drives only low; 0 push-pull; inputs unaffected
// (R3) port m data read gives stored value for outputs, pin level for inputs
// (R4) port m pin-level register always returns pin levels; writes ignored
// (R5) port m direction bit 0 input, 1 output, unless a peripheral overrides
// (R6) enabled spi or can controller decides direction of its port m pins
// (R7) enabled transmit channel forces output, enabled receive channel forces input
// (R8) disabling an overriding channel returns direction to the direction bit
// (R9) reads may take up to 2 bus cycles to follow a direction change
// (R10) port m weak-drive bit 1 gives reduced strength; ignored on inputs
// (R11) port m pull-enable acts only on inputs or wired-or outputs
// (R12) port m pull devices come out of reset enabled as pull-ups
// (R13) spi pins of port m are governed by spi controller status inputs
// (R14) port s pull-enable 0 disables, 1 enables device chosen by polarity
// (R15) unimplemented upper bits read zero and ignore writes
module port_pin_control
#(
    parameter int M_WIDTH = 6,
    parameter int S_WIDTH = 4
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire port_pins_pkg::apb_word_t pwdata,
    output port_pins_pkg::apb_word_t prdata,
    output logic pready,
    output logic pslverr,
    // port s: data and direction come from the rest of the port s logic
    input wire logic [S_WIDTH-1:0] s_out_value,
    input wire logic [S_WIDTH-1:0] s_out_dir,
    output logic [S_WIDTH-1:0] s_pin_o,
    output logic [S_WIDTH-1:0] s_pin_oe,
    output logic [S_WIDTH-1:0] s_pull_up_en,
    output logic [S_WIDTH-1:0] s_pull_dn_en,
    // port m pins
    input wire logic [M_WIDTH-1:0] m_pin_i,
    output logic [M_WIDTH-1:0] m_pin_o,
    output logic [M_WIDTH-1:0] m_pin_oe,
    output logic [M_WIDTH-1:0] m_weak_drive_out,
    output logic [M_WIDTH-1:0] m_pull_up_en,
    // spi controller on the m_spi_pins
    input wire logic spi_enable,
    input wire logic [3:0] spi_pin_dir,
    input wire logic [3:0] spi_pin_data,
    // can and sci channels on the two low port m pins
    input wire logic can_enable,
    input wire logic can_tx_data,
    input wire logic sci_tx_enable,
    input wire logic sci_rx_enable,
    input wire logic sci_tx_data
);
    import port_pins_pkg::*;
    // the pin map is fixed at six port m pins; port s fits one register byte
    if (M_WIDTH != 6 || S_WIDTH < 1 || S_WIDTH > 8) begin : g_bad_width
        $error("port_pin_control: unsupported port widths");
    end
    localparam reg_byte_t S_MASK = reg_byte_t'((1 << S_WIDTH) - 1);
    localparam reg_byte_t M_MASK = reg_byte_t'((1 << M_WIDTH) - 1);

    reg_byte_t s_pull_on_q, s_pull_on_d;
    reg_byte_t s_pull_polarity_q, s_pull_polarity_d;
    reg_byte_t s_open_drain_sel_q, s_open_drain_sel_d;
    reg_byte_t m_output_value_q, m_output_value_d;
    reg_byte_t m_direction_bits_q, m_direction_bits_d;
    reg_byte_t m_weak_drive_q, m_weak_drive_d;
    reg_byte_t m_pull_on_q, m_pull_on_d;

    apb_phase_t phase_q, phase_d;
    apb_word_t prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [5:0] reg_idx;
    logic addr_ok;
    logic wr_fire;
    reg_byte_t wbyte;
    reg_byte_t rd_value;

    // state for pins and reads
    logic [M_WIDTH-1:0] m_pin_sample_q;
    logic [M_WIDTH-1:0] m_dir_eff_q;
    logic [M_WIDTH-1:0] m_dir_eff;
    logic [M_WIDTH-1:0] m_drive_val;

    assign reg_idx = paddr[7:2];
    assign wbyte = pwdata[7:0];
    assign wr_fire = psel && penable && pready_q && pwrite && !pslverr_q;

    always_comb begin
        addr_ok = (paddr[1:0] == 2'b00);
        unique case ({2'b00, reg_idx})
            `S_PULL_ON_IDX, `S_PULL_POLARITY_IDX, `S_OPEN_DRAIN_IDX,
            `M_DATA_IDX, `M_PIN_LEVEL_IDX, `M_DIRECTION_IDX,
            `M_DRIVE_IDX, `M_PULL_ON_IDX: begin
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    // read data multiplexer; reads use the registered direction and pin sample
    always_comb begin
        rd_value = 8'h00;
        unique case ({2'b00, reg_idx})
            `S_PULL_ON_IDX: begin
                rd_value = s_pull_on_q & S_MASK; // R15
            end
            `S_PULL_POLARITY_IDX: begin
                rd_value = s_pull_polarity_q & S_MASK;
            end
            `S_OPEN_DRAIN_IDX: begin
                rd_value = s_open_drain_sel_q & S_MASK;
            end
            `M_DATA_IDX: begin
                rd_value = reg_byte_t'((m_dir_eff_q & m_output_value_q[M_WIDTH-1:0])
                    | (~m_dir_eff_q & m_pin_sample_q)); // R3 R9
            end
            `M_PIN_LEVEL_IDX: begin
                rd_value = reg_byte_t'(m_pin_sample_q); // R4
            end
            `M_DIRECTION_IDX: begin
                rd_value = m_direction_bits_q & M_MASK;
            end
            `M_DRIVE_IDX: begin
                rd_value = m_weak_drive_q & M_MASK;
            end
            `M_PULL_ON_IDX: begin
                rd_value = m_pull_on_q & M_MASK;
            end
            default: begin
                rd_value = 8'h00;
            end
        endcase
    end

    // setup cycle prepares the answer; access phase completes one cycle later
    always_comb begin
        phase_d = phase_q;
        prdata_d = prdata_q;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        unique case (phase_q)
            APB_IDLE, APB_ACCESS: begin
                if (psel && !penable) begin
                    phase_d = APB_SETUP;
                    pready_d = 1'b1;
                    pslverr_d = !addr_ok;
                    prdata_d = (addr_ok && !pwrite) ? {24'h000000, rd_value} : 32'h00000000;
                end else begin
                    phase_d = APB_IDLE;
                end
            end
            APB_SETUP: begin
                phase_d = APB_ACCESS;
                pslverr_d = pslverr_q;
            end
            default: begin
                phase_d = APB_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= APB_IDLE;
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // register writes; the pin-level register has no write path
    always_comb begin
        s_pull_on_d = s_pull_on_q;
        s_pull_polarity_d = s_pull_polarity_q;
        s_open_drain_sel_d = s_open_drain_sel_q;
        m_output_value_d = m_output_value_q;
        m_direction_bits_d = m_direction_bits_q;
        m_weak_drive_d = m_weak_drive_q;
        m_pull_on_d = m_pull_on_q;
        if (wr_fire) begin
            unique case ({2'b00, reg_idx})
                `S_PULL_ON_IDX: begin
                    s_pull_on_d = wbyte & S_MASK; // R15
                end
                `S_PULL_POLARITY_IDX: begin
                    s_pull_polarity_d = wbyte & S_MASK;
                end
                `S_OPEN_DRAIN_IDX: begin
                    s_open_drain_sel_d = wbyte & S_MASK;
                end
                `M_DATA_IDX: begin
                    m_output_value_d = wbyte & M_MASK;
                end
                `M_DIRECTION_IDX: begin
                    m_direction_bits_d = wbyte & M_MASK;
                end
                `M_DRIVE_IDX: begin
                    m_weak_drive_d = wbyte & M_MASK;
                end
                `M_PULL_ON_IDX: begin
                    m_pull_on_d = wbyte & M_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_pull_on_q <= `S_PULL_ON_RST;
            s_pull_polarity_q <= `S_PULL_POLARITY_RST;
            s_open_drain_sel_q <= `S_OPEN_DRAIN_RST;
            m_output_value_q <= `M_DATA_RST;
            m_direction_bits_q <= `M_DIRECTION_RST;
            m_weak_drive_q <= `M_DRIVE_RST;
            m_pull_on_q <= `M_PULL_ON_RST; // R12
        end else begin
            s_pull_on_q <= s_pull_on_d;
            s_pull_polarity_q <= s_pull_polarity_d;
            s_open_drain_sel_q <= s_open_drain_sel_d;
            m_output_value_q <= m_output_value_d;
            m_direction_bits_q <= m_direction_bits_d;
            m_weak_drive_q <= m_weak_drive_d;
            m_pull_on_q <= m_pull_on_d;
        end
    end

    // overrides are evaluated live, so a channel switched off hands back at once
    always_comb begin
        m_dir_eff = m_direction_bits_q[M_WIDTH-1:0]; // R5 R8
        m_drive_val = m_output_value_q[M_WIDTH-1:0];
        if (spi_enable) begin
            m_dir_eff[`M_SPI_LSB +: 4] = spi_pin_dir; // R6 R13
            m_drive_val[`M_SPI_LSB +: 4] = spi_pin_data;
        end
        if (can_enable || sci_rx_enable) begin
            m_dir_eff[`M_RX_PIN] = 1'b0; // R6 R7
        end
        if (can_enable) begin
            m_dir_eff[`M_TX_PIN] = 1'b1; // R6 R7
            m_drive_val[`M_TX_PIN] = can_tx_data;
        end else if (sci_tx_enable) begin
            m_dir_eff[`M_TX_PIN] = 1'b1; // R7
            m_drive_val[`M_TX_PIN] = sci_tx_data;
        end
    end

    // pin sample and direction each pass one flop; reads settle within two cycles
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            m_pin_sample_q <= '0;
            m_dir_eff_q <= '0;
        end else begin
            m_pin_sample_q <= m_pin_i; // R4
            m_dir_eff_q <= m_dir_eff; // R9
        end
    end

    logic [M_WIDTH-1:0] m_pin_o_q, m_pin_oe_q, m_weak_q, m_pull_up_q;
    logic [S_WIDTH-1:0] s_pin_o_q, s_pin_oe_q, s_pull_up_q, s_pull_dn_q;
    logic [M_WIDTH-1:0] m_pin_o_d, m_pin_oe_d, m_weak_d, m_pull_up_d;
    logic [S_WIDTH-1:0] s_pin_o_d, s_pin_oe_d, s_pull_up_d, s_pull_dn_d;

    genvar gi;
    generate
        for (gi = 0; gi < M_WIDTH; gi++) begin : g_m_pin
            always_comb begin
                m_pin_oe_d[gi] = m_dir_eff[gi];
                m_pin_o_d[gi] = m_drive_val[gi];
                m_weak_d[gi] = m_dir_eff[gi] & m_weak_drive_q[gi]; // R10
                // port m outputs are push-pull here, so pulls apply to inputs only
                m_pull_up_d[gi] = m_pull_on_q[gi] & ~m_dir_eff[gi]; // R11 R12
            end
        end
        for (gi = 0; gi < S_WIDTH; gi++) begin : g_s_pin
            logic pull_active;
            always_comb begin
                // open-drain output never drives a high level
                s_pin_o_d[gi] = s_out_value[gi] & ~s_open_drain_sel_q[gi]; // R2
                s_pin_oe_d[gi] = s_out_dir[gi]
                    & ~(s_open_drain_sel_q[gi] & s_out_value[gi]); // R2
                pull_active = s_pull_on_q[gi]
                    & (~s_out_dir[gi] | s_open_drain_sel_q[gi]); // R1 R14
                s_pull_up_d[gi] = pull_active & ~s_pull_polarity_q[gi]; // R1
                s_pull_dn_d[gi] = pull_active & s_pull_polarity_q[gi]; // R1
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            m_pin_o_q <= '0;
            m_pin_oe_q <= '0;
            m_weak_q <= '0;
            m_pull_up_q <= '1;
            s_pin_o_q <= '0;
            s_pin_oe_q <= '0;
            s_pull_up_q <= '1;
            s_pull_dn_q <= '0;
        end else begin
            m_pin_o_q <= m_pin_o_d;
            m_pin_oe_q <= m_pin_oe_d;
            m_weak_q <= m_weak_d;
            m_pull_up_q <= m_pull_up_d;
            s_pin_o_q <= s_pin_o_d;
            s_pin_oe_q <= s_pin_oe_d;
            s_pull_up_q <= s_pull_up_d;
            s_pull_dn_q <= s_pull_dn_d;
        end
    end

    assign m_pin_o = m_pin_o_q;
    assign m_pin_oe = m_pin_oe_q;
    assign m_weak_drive_out = m_weak_q;
    assign m_pull_up_en = m_pull_up_q;
    assign s_pin_o = s_pin_o_q;
    assign s_pin_oe = s_pin_oe_q;
    assign s_pull_up_en = s_pull_up_q;
    assign s_pull_dn_en = s_pull_dn_q;

endmodule // port_pin_control

// file: bench/port_pin_control_assertions.sv
`timescale 1ns/1ps
module port_pin_control_assertions (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic [3:0] s_out_dir,
    input wire logic [3:0] s_pin_oe,
    input wire logic [3:0] s_pull_up_en,
    input wire logic [3:0] s_pull_dn_en,
    input wire logic [5:0] m_pin_o,
    input wire logic [5:0] m_pin_oe,
    input wire logic [5:0] m_weak_drive_out,
    input wire logic [5:0] m_pull_up_en,
    input wire logic spi_enable,
    input wire logic [3:0] spi_pin_dir,
    input wire logic can_enable,
    input wire logic can_tx_data,
    input wire logic sci_tx_enable,
    input wire logic sci_tx_data
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    chk_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("bad apb answer");
    chk_reset_pulls: assert property ($rose(reset_n) |-> m_pull_up_en == 6'h3f)
        else $error("pull-ups off after reset");
    chk_s_one_pull: assert property ((s_pull_up_en & s_pull_dn_en) == 4'h0)
        else $error("both pulls on");
    chk_s_oe_dir: assert property ((s_pin_oe & ~$past(s_out_dir)) == 4'h0)
        else $error("port s input driven");
    chk_m_weak_out: assert property ((m_weak_drive_out & ~m_pin_oe) == 6'h0)
        else $error("weak drive on input");
    chk_m_pull_in: assert property ((m_pull_up_en & m_pin_oe) == 6'h0)
        else $error("pull on output");
    chk_spi_dir: assert property (spi_enable |=> m_pin_oe[5:2] == $past(spi_pin_dir))
        else $error("spi pin direction");
    chk_can_pins: assert property (can_enable |=>
        m_pin_oe[1:0] == 2'b10 && m_pin_o[1] == $past(can_tx_data))
        else $error("can pins");
    chk_sci_tx: assert property (sci_tx_enable && !can_enable |=>
        m_pin_oe[1] && m_pin_o[1] == $past(sci_tx_data))
        else $error("sci transmit pin");
    cov_spi: cover property (spi_enable ##1 spi_enable);
    cov_can: cover property (can_enable);
    cov_xfer: cover property (psel && penable && pready);
endmodule // port_pin_control_assertions
bind port_pin_control port_pin_control_assertions u_chk (.sys_clk, .reset_n, .psel,
    .penable, .pready, .s_out_dir, .s_pin_oe, .s_pull_up_en, .s_pull_dn_en, .m_pin_o,
    .m_pin_oe, .m_weak_drive_out, .m_pull_up_en, .spi_enable, .spi_pin_dir, .can_enable,
    .can_tx_data, .sci_tx_enable, .sci_tx_data);

// file: bench/pin_world.sv
`timescale 1ns/1ps
module pin_world (
    input wire logic sys_clk,
    input wire logic [5:0] m_pin_o,
    input wire logic [5:0] m_pin_oe,
    input wire logic [5:0] m_pull_up_en,
    input wire logic [5:0] ext_en,
    input wire logic [5:0] ext_val,
    input wire logic [5:0] short_mask,
    output logic [5:0] m_pin_i
);
    logic [5:0] float_q = 6'h15;
    // an undriven pin with no pull wanders every cycle
    always @(posedge sys_clk) float_q <= ~float_q;
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (m_pin_oe[i]) m_pin_i[i] = m_pin_o[i] ^ short_mask[i];
            else if (ext_en[i]) m_pin_i[i] = ext_val[i];
            else if (m_pull_up_en[i]) m_pin_i[i] = 1'b1;
            else m_pin_i[i] = float_q[i];
        end
    end
endmodule // pin_world

// file: bench/port_pin_control_s_m_test.sv
`timescale 1ns/1ps
module port_pin_control_s_m_test;
    logic sys_clk = '0, reset_n = '0, psel = '0, penable = '0, pwrite = '0;
    logic spi_enable = '0, can_enable = '0, can_tx_data = '0, sci_tx_enable = '0;
    logic sci_rx_enable = '0, sci_tx_data = '0, pready, pslverr;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rnd;
    logic [3:0] s_out_value = '0, s_out_dir = '0, spi_pin_dir = '0, spi_pin_data = '0;
    logic [3:0] s_pin_o, s_pin_oe, s_pull_up_en, s_pull_dn_en, p, e, w;
    logic [5:0] m_pin_i, m_pin_o, m_pin_oe, m_weak_drive_out, m_pull_up_en, v, d, r, pe;
    logic [5:0] ext_en = '0, ext_val = '0, short_mask = '0;
    logic [9:0] q[$], nt;
    int num_errors = 0, n_checks = 0, seed = 5;
    always #25 sys_clk = ~sys_clk;
    port_pin_control u_dut (.sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .s_out_value, .s_out_dir, .s_pin_o, .s_pin_oe,
        .s_pull_up_en, .s_pull_dn_en, .m_pin_i, .m_pin_o, .m_pin_oe, .m_weak_drive_out,
        .m_pull_up_en, .spi_enable, .spi_pin_dir, .spi_pin_data, .can_enable, .can_tx_data,
        .sci_tx_enable, .sci_rx_enable, .sci_tx_data);
    pin_world u_pins (.sys_clk, .m_pin_o, .m_pin_oe, .m_pull_up_en, .ext_en, .ext_val,
        .short_mask, .m_pin_i);
    task automatic check(input string nm, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        if (num_errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, dat, exp, input logic er);
        int n;
        q.push_back({wr, er, exp});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, dat};
        @(posedge sys_clk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            num_errors++;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    // the oldest note is judged when the slave answers
    always @(posedge sys_clk) begin
        if (psel && penable && pready === 1'b1 && q.size() > 0) begin
            nt = q.pop_front();
            check("pslverr", pslverr, nt[8]);
            if (!nt[9]) check("prdata", prdata, {24'h0, nt[7:0]});
        end
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        check("m_pull_up", m_pull_up_en, 6'h3f);
        apb(1'b0, 8'h30, 8'h0, 8'h0f, 1'b0);
        apb(1'b0, 8'h50, 8'h0, 8'h3f, 1'b0);
        apb(1'b0, 8'h40, 8'h0, 8'h3f, 1'b0);
        apb(1'b0, 8'h48, 8'h0, 8'h00, 1'b0);
        apb(1'b1, 8'h44, 8'h00, 8'h0, 1'b0);
        apb(1'b0, 8'h44, 8'h0, 8'h3f, 1'b0);
        apb(1'b1, 8'h50, 8'hff, 8'h0, 1'b0);
        apb(1'b0, 8'h50, 8'h0, 8'h3f, 1'b0);
        apb(1'b1, 8'h3c, 8'h01, 8'h0, 1'b1);
        apb(1'b0, 8'h41, 8'h0, 8'h00, 1'b1);
        for (int i = 0; i < 4; i++) begin
            rnd = $random(seed);
            {w, e, p} = {rnd[19:16], rnd[11:8], rnd[3:0]};
            apb(1'b1, 8'h34, rnd[7:0], 8'h0, 1'b0);
            apb(1'b1, 8'h30, rnd[15:8], 8'h0, 1'b0);
            apb(1'b1, 8'h38, rnd[23:16], 8'h0, 1'b0);
            s_out_dir <= rnd[27:24];
            s_out_value <= rnd[31:28];
            repeat (2) @(posedge sys_clk);
            check("s_oe", s_pin_oe, s_out_dir & ~(w & s_out_value));
            check("s_o", s_pin_o, s_out_value & ~w);
            check("s_pu", s_pull_up_en, e & ~p & (~s_out_dir | w));
            check("s_pd", s_pull_dn_en, e & p & (~s_out_dir | w));
        end
        ext_en <= 6'h3f;
        for (int i = 0; i < 4; i++) begin
            rnd = $random(seed);
            {pe, r, d, v} = rnd[23:0];
            rnd = $random(seed);
            ext_val <= rnd[5:0];
            short_mask <= rnd[11:6];
            apb(1'b1, 8'h40, {2'h0, v}, 8'h0, 1'b0);
            apb(1'b1, 8'h4c, {2'h0, r}, 8'h0, 1'b0);
            apb(1'b1, 8'h50, {2'h0, pe}, 8'h0, 1'b0);
            apb(1'b1, 8'h48, {2'h0, d}, 8'h0, 1'b0);
            // pins turned round need one more cycle before the data read
            @(posedge sys_clk);
            apb(1'b0, 8'h40, 8'h0, {2'h0, v & d | ext_val & ~d}, 1'b0);
            apb(1'b0, 8'h44, 8'h0, {2'h0, (v ^ short_mask) & d | ext_val & ~d}, 1'b0);
            check("m_oe", m_pin_oe, d);
            check("m_o", m_pin_o & d, v & d);
            check("m_weak", m_weak_drive_out, r & d);
            check("m_pull", m_pull_up_en, pe & ~d);
        end
        apb(1'b1, 8'h48, 8'h3f, 8'h0, 1'b0);
        for (int k = 0; k < 2; k++) begin
            rnd = $random(seed);
            can_enable <= (k == 0);
            can_tx_data <= rnd[8];
            sci_tx_enable <= (k == 1);
            sci_rx_enable <= (k == 1);
            sci_tx_data <= ~rnd[8];
            spi_enable <= 1'b1;
            {spi_pin_data, spi_pin_dir} <= rnd[7:0];
            repeat (2) @(posedge sys_clk);
            d = {spi_pin_dir, 2'b10};
            check("m_oe", m_pin_oe, d);
            check("m_o", m_pin_o & d, {spi_pin_data & spi_pin_dir,
                k == 0 ? can_tx_data : sci_tx_data, 1'b0});
        end
        {can_enable, sci_tx_enable, sci_rx_enable, spi_enable} <= 4'h0;
        repeat (2) @(posedge sys_clk);
        check("m_oe", m_pin_oe, 6'h3f);
        // a second reset in mid-run must restore the port m pull-enable and direction defaults
        reset_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        check("m_pull_up", m_pull_up_en, 6'h3f);
        apb(1'b0, 8'h50, 8'h0, 8'h3f, 1'b0);
        apb(1'b0, 8'h48, 8'h0, 8'h00, 1'b0);
        check("m_oe", m_pin_oe, 6'h00);
        tally_and_finish();
    end
endmodule // port_pin_control_s_m_test
